// *** bench/tone_header_wakeup_detector_test.sv ***
// testbench for the tone header wake-up detector
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_errors++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tone_header_wakeup_detector_test;
  logic CLK = 0, RST_N = 0, run_req = 0, sweep = 0, data = 0, ce = 1;
  logic shut, wake_n, standby, boost, swept;
  logic [8:0] lo;
  int n_errors = 0, samples_checked = 0, cycles = 0, wakes, n;
  initial forever #10 CLK = ~CLK;
  twd_host_model u_twd_host_model (.CLK(CLK), .RST_N(RST_N),
    .WAKE_ALERT_N(wake_n), .run_req(run_req), .SHUTDOWN(shut),
    .wake_count(wakes));
  twd_detector #(.TONE_DIV(4), .TONE_CYCLES(4), .BOOST_CYCLES(20))
    u_twd_detector (.CLK(CLK), .RST_N(RST_N), .CE(ce),
    .SHUTDOWN(shut), .SWEEP_MODE_SELECT(sweep), .DEMOD_DATA(data),
    .WAKE_ALERT_N(wake_n), .STANDBY(standby), .AGC_BOOST(boost),
    .SWEPT_LO_MODE(swept), .LO_MULT_Q(lo));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task print_verdict;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  task cyc(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask
  task wait_wake(input logic lvl, input int mx);
    n = 0;
    while (wake_n !== lvl && n < mx)
    begin
      cyc(1);
      n++;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    `CHK("wake", 1'b1, wake_n)
    `CHK("standby", 1'b1, standby)
    `CHK("lo", 9'h102, lo)
  endtask
  task t_lo_mode;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge CLK) sweep <= i[0];
      cyc(2);
      `CHK("swept", i[0], swept)
      `CHK("lo", i ? 9'h101 : 9'h102, lo)
    end
  endtask
  task t_boost;
    @(posedge CLK) run_req <= 1'b1;
    cyc(4);
    `CHK("standby", 1'b0, standby)
    `CHK("boost", 1'b1, boost)
    cyc(16);
    `CHK("boost last", 1'b1, boost)
    cyc(1);
    `CHK("boost", 1'b0, boost)
  endtask
  task t_tone;
    // tone well over the qualifying length
    @(posedge CLK) data <= 1'b1;
    cyc(18);
    `CHK("early", 1'b1, wake_n)
    wait_wake(1'b0, 20);
    `CHK("wake", 1'b0, wake_n)
    `CHK("latency", 1, n)
    cyc(10);
    `CHK("held", 1'b0, wake_n)
    @(posedge CLK) data <= 1'b0;
    cyc(2);
    `CHK("release", 1'b1, wake_n)
    `CHK("count", 1, wakes)
  endtask
  task t_break;
    @(posedge CLK) data <= 1'b1;
    cyc(12);
    @(posedge CLK) data <= 1'b0;
    @(posedge CLK) data <= 1'b1;
    cyc(13);
    `CHK("restart", 1'b1, wake_n)
    wait_wake(1'b0, 20);
    `CHK("wake", 1'b0, wake_n)
  endtask
  task t_shutdown;
    @(posedge CLK) run_req <= 1'b0;
    cyc(3);
    `CHK("wake", 1'b1, wake_n)
    `CHK("standby", 1'b1, standby)
    cyc(40);
    `CHK("no wake", 1'b1, wake_n)
    @(posedge CLK) data <= 1'b0;
  endtask
  task t_freeze;
    @(posedge CLK)
    begin
      ce <= 1'b0;
      run_req <= 1'b1;
    end
    cyc(4);
    `CHK("frozen standby", 1'b1, standby)
    `CHK("frozen boost", 1'b0, boost)
    @(posedge CLK) ce <= 1'b1;
    cyc(2);
    `CHK("standby", 1'b0, standby)
    `CHK("boost", 1'b1, boost)
  endtask
  initial
  begin
    cyc(5);
    @(posedge CLK) RST_N <= 1'b1;
    cyc(1);
    t_reset();
    t_lo_mode();
    t_boost();
    t_tone();
    t_break();
    t_shutdown();
    t_freeze();
    print_verdict();
  end
endmodule // tone_header_wakeup_detector_test

// *** bench/twd_host_model.sv ***
// controller model facing the wake alert and shutdown pins
`timescale 1ns/1ps
module twd_host_model (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WAKE_ALERT_N,
  input wire logic run_req,
  output logic SHUTDOWN,
  output int wake_count
);
  logic wake_q;
  // ----------------------------------------
  // shutdown drive, high like the pull-up
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      SHUTDOWN <= 1'b1;
    else
      SHUTDOWN <= ~run_req;
  // ----------------------------------------
  // wake alert counting
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      wake_q <= 1'b1;
      wake_count <= 0;
    end
    else
    begin
      wake_q <= WAKE_ALERT_N;
      if (wake_q && !WAKE_ALERT_N)
        wake_count <= wake_count + 1;
    end
endmodule // twd_host_model

// *** verilog/twd_detector.sv ***
// tone header wake-up detector with shutdown and boost timing
`timescale 1ns/1ps

module twd_detector #(
  parameter int TONE_DIV = twd_pkg::TONE_DIV,
  parameter int TONE_CYCLES = twd_pkg::TONE_CYCLES,
  parameter int BOOST_CYCLES = twd_pkg::BOOST_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic SHUTDOWN,
  input wire logic SWEEP_MODE_SELECT,
  input wire logic DEMOD_DATA,
  output logic WAKE_ALERT_N,
  output logic STANDBY,
  output logic AGC_BOOST,
  output logic SWEPT_LO_MODE,
  output logic [8:0] LO_MULT_Q
);
  localparam int CW = $clog2(TONE_CYCLES + 1);
  localparam int BW = $clog2(BOOST_CYCLES + 1);
  localparam int TW = $clog2(TONE_DIV + 1);
  localparam int LW = $clog2(TONE_DIV * TONE_CYCLES + 1);

  twd_pkg::twd_state_t state;
  logic [CW-1:0] tone_count;
  logic [BW-1:0] boost_count;
  logic data_prev;
  logic tone_tick;
  logic data_edge;
  logic running;
  logic div_run;
  logic [TW-1:0] tick_gap;
  logic [LW-1:0] tone_len;

  assign data_edge = DEMOD_DATA != data_prev;
  assign running = !SHUTDOWN && (state != twd_pkg::TWD_STANDBY);
  assign div_run = running && !data_edge;

  // ---------------------------------------------------------------
  // tone clock
  // ---------------------------------------------------------------
  twd_divider #(
    .DIV(TONE_DIV)
  ) u_div (
    .CLK(CLK),
    .RST_N(RST_N),
    .CE(CE),
    .run(div_run),
    .tick(tone_tick)
  );

  // ---------------------------------------------------------------
  // data edge history
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      data_prev <= ~twd_pkg::TONE_LEVEL;
    else if (CE)
      data_prev <= DEMOD_DATA;
  end

  // ---------------------------------------------------------------
  // wake state machine
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      state <= twd_pkg::TWD_STANDBY;
    else if (CE)
    begin
      if (SHUTDOWN)
        state <= twd_pkg::TWD_STANDBY;
      else
      begin
        unique case (state)
          twd_pkg::TWD_STANDBY:
            state <= twd_pkg::TWD_HUNT;
          twd_pkg::TWD_HUNT:
            if (tone_tick && tone_count == CW'(TONE_CYCLES - 1) &&
                !data_edge && DEMOD_DATA == twd_pkg::TONE_LEVEL)
              state <= twd_pkg::TWD_ALERT;
          twd_pkg::TWD_ALERT:
            if (data_edge)
              state <= twd_pkg::TWD_HUNT;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // tone qualification counter
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      tone_count <= '0;
    else if (CE)
    begin
      if (!running || data_edge || DEMOD_DATA != twd_pkg::TONE_LEVEL ||
          state != twd_pkg::TWD_HUNT)
        tone_count <= '0;
      else if (tone_tick && tone_count != CW'(TONE_CYCLES))
        tone_count <= tone_count + CW'(1);
    end
  end

  // ---------------------------------------------------------------
  // boost interval
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      boost_count <= '0;
    else if (CE)
    begin
      if (SHUTDOWN)
        boost_count <= BW'(BOOST_CYCLES);
      else if (boost_count != '0)
        boost_count <= boost_count - BW'(1);
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      WAKE_ALERT_N <= 1'b1;
      STANDBY <= 1'b1;
      AGC_BOOST <= 1'b0;
      SWEPT_LO_MODE <= 1'b0;
      LO_MULT_Q <= twd_pkg::LO_MULT_FIXED_Q;
    end
    else if (CE)
    begin
      WAKE_ALERT_N <= !(state == twd_pkg::TWD_ALERT && !SHUTDOWN &&
                        !data_edge);
      STANDBY <= SHUTDOWN;
      AGC_BOOST <= !SHUTDOWN && boost_count > BW'(1);
      SWEPT_LO_MODE <= SWEEP_MODE_SELECT;
      LO_MULT_Q <= SWEEP_MODE_SELECT ? twd_pkg::LO_MULT_SWEPT_Q
                                     : twd_pkg::LO_MULT_FIXED_Q;
    end
  end

  // ---------------------------------------------------------------
  // tone tick spacing monitor
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      tick_gap <= '0;
    else if (CE)
    begin
      if (!div_run)
        tick_gap <= '0;
      else if (tone_tick)
        tick_gap <= TW'(1);
      else if (tick_gap != TW'(TONE_DIV))
        tick_gap <= tick_gap + TW'(1);
    end
  end

  // ---------------------------------------------------------------
  // steady tone length monitor
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      tone_len <= '0;
    else if (CE)
    begin
      if (!div_run || DEMOD_DATA != twd_pkg::TONE_LEVEL)
        tone_len <= '0;
      else if (tone_len != LW'(TONE_DIV * TONE_CYCLES))
        tone_len <= tone_len + LW'(1);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  shut_no_wake_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && SHUTDOWN |=> WAKE_ALERT_N)
    else $error("wake alert during shutdown");

  alert_needs_count_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && $changed(state) && state == twd_pkg::TWD_ALERT |->
      $past(tone_count) == CW'(TONE_CYCLES - 1))
    else $error("alert without full tone count");

  break_resets_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && data_edge |=> tone_count == '0)
    else $error("tone count survived a data edge");

  alert_release_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && state == twd_pkg::TWD_ALERT && data_edge && !SHUTDOWN |=>
      WAKE_ALERT_N && state == twd_pkg::TWD_HUNT)
    else $error("alert not released on data");

  alert_hold_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && state == twd_pkg::TWD_ALERT && !data_edge && !SHUTDOWN |=>
      !WAKE_ALERT_N)
    else $error("alert not driven low");

  standby_follow_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE |=> STANDBY == $past(SHUTDOWN))
    else $error("standby does not follow shutdown");

  lo_mode_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && !SWEEP_MODE_SELECT |=> LO_MULT_Q == twd_pkg::LO_MULT_FIXED_Q)
    else $error("fixed multiplier wrong");

  lo_swept_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && SWEEP_MODE_SELECT |=>
      LO_MULT_Q == twd_pkg::LO_MULT_SWEPT_Q && SWEPT_LO_MODE)
    else $error("swept multiplier wrong");

  boost_start_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && $fell(SHUTDOWN) |=> AGC_BOOST)
    else $error("boost missing after shutdown");

  tick_period_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE |-> tone_tick == (tick_gap == TW'(TONE_DIV)))
    else $error("tone tick spacing wrong");

  tick_gated_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && !div_run |=> !tone_tick)
    else $error("tone tick while stopped");

  count_on_tick_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && !tone_tick |=>
      tone_count == '0 || tone_count == $past(tone_count))
    else $error("tone count moved without tick");

  tone_length_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && $changed(state) && state == twd_pkg::TWD_ALERT |->
      $past(tone_len) == LW'(TONE_DIV * TONE_CYCLES))
    else $error("alert after wrong tone length");

  alert_on_time_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && !SHUTDOWN && !data_edge && state == twd_pkg::TWD_HUNT &&
      tone_len == LW'(TONE_DIV * TONE_CYCLES) |=>
      state == twd_pkg::TWD_ALERT)
    else $error("alert late after full tone");

  low_data_hunt_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && state == twd_pkg::TWD_HUNT &&
      DEMOD_DATA != twd_pkg::TONE_LEVEL |=> state != twd_pkg::TWD_ALERT)
    else $error("alert without carrier level");

  shut_clear_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && SHUTDOWN |=> state == twd_pkg::TWD_STANDBY && tone_count == '0)
    else $error("detection not cleared in shutdown");

  standby_exit_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && !SHUTDOWN && state == twd_pkg::TWD_STANDBY |=>
      state == twd_pkg::TWD_HUNT)
    else $error("standby not left on release");

  wake_only_alert_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && state != twd_pkg::TWD_ALERT |=> WAKE_ALERT_N)
    else $error("wake alert outside alert state");

  boost_load_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && SHUTDOWN |=> !AGC_BOOST && boost_count == BW'(BOOST_CYCLES))
    else $error("boost not armed in shutdown");

  boost_step_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && !SHUTDOWN && boost_count != '0 |=>
      boost_count == $past(boost_count) - BW'(1))
    else $error("boost interval not counted per cycle");

  boost_end_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && !SHUTDOWN && boost_count <= BW'(1) |=> !AGC_BOOST)
    else $error("boost outlasted its interval");

  ce_freeze_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !CE |=> $stable(state) && $stable(tone_count) && $stable(tone_tick) &&
      $stable(boost_count) && $stable(WAKE_ALERT_N) && $stable(STANDBY))
    else $error("state moved with clock enable low");

  lo_fixed_flag_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CE && !SWEEP_MODE_SELECT |=> !SWEPT_LO_MODE)
    else $error("fixed mode flag wrong");
endmodule // twd_detector

// *** verilog/twd_divider.sv ***
// tone clock divider derived from the reference clock
`timescale 1ns/1ps
module twd_divider #(
  parameter int DIV = twd_pkg::TONE_DIV
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic run,
  output logic tick
);
  localparam int W = $clog2(DIV);
  logic [W-1:0] count;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else if (CE)
    begin
      if (!run)
      begin
        count <= '0;
        tick <= 1'b0;
      end
      else if (count == W'(DIV - 1))
      begin
        count <= '0;
        tick <= 1'b1;
      end
      else
      begin
        count <= count + W'(1);
        tick <= 1'b0;
      end
    end
  end
endmodule // twd_divider

// *** verilog/twd_pkg.sv ***
// package of constants for the tone header wake-up detector
package twd_pkg;
  // ---------------------------------------------------------------
  // reference and tone clock timing
  // ---------------------------------------------------------------
  localparam int REF_HZ_NOMINAL = 6400000;
  localparam int TONE_HZ_NOMINAL = 25000;
  // reference cycles per tone clock cycle (256 at nominal)
  localparam int TONE_DIV = REF_HZ_NOMINAL / TONE_HZ_NOMINAL;
  localparam int TONE_CYCLES = 128;
  // ---------------------------------------------------------------
  // boost interval after leaving shutdown
  // ---------------------------------------------------------------
  localparam int BOOST_US_AT_6M = 10900;
  localparam int BOOST_REF_MHZ = 6;
  // reference cycles of boost, sized for a 6 MHz reference
  localparam int BOOST_CYCLES = BOOST_US_AT_6M * BOOST_REF_MHZ;
  // ---------------------------------------------------------------
  // local oscillator multipliers, in quarter units
  // ---------------------------------------------------------------
  localparam logic [8:0] LO_MULT_FIXED_Q = 9'h102; // 64.5
  localparam logic [8:0] LO_MULT_SWEPT_Q = 9'h101; // 64.25
  // ---------------------------------------------------------------
  // data level meaning carrier present
  // ---------------------------------------------------------------
  localparam logic TONE_LEVEL = 1'b1;

  typedef enum logic [1:0] {TWD_STANDBY, TWD_HUNT, TWD_ALERT} twd_state_t;
endpackage
